// >>> hw/cfcm_sum.sv
`timescale 1ns/100ps
module cfcm_sum import cfcm_pkg::*; #(
   parameter int unsigned N_CFG = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Control side
   cfcm_sum_if.eng  sif
);
   localparam int unsigned IW = (N_CFG > 1) ? $clog2(N_CFG) : 1;

   cfcm_eng_t       st_ff;   // Engine state
   cfcm_eng_t       nxt_st;  // Next state
   logic            chk_ff;  // Compare pass, not store
   logic [13:0]     acc_ff;  // Running sum
   logic [13:0]     sto_ff;  // Hidden stored checksum
   logic [IW-1:0]   idx_ff;  // Register walk index
   wire logic       last;    // Final register this cycle
   wire logic [13:0] sum;    // Sum including current word

   assign last         = idx_ff == IW'(N_CFG - 1);
   assign sum          = acc_ff + sif.word;
   assign sif.idx      = idx_ff;
   assign sif.busy     = st_ff == ENG_RUN;
   // Mismatch raised while still busy so it lands before next command
   assign sif.mismatch = sif.busy & chk_ff & last & (sum != sto_ff);

   // State sequencing
   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         ENG_IDLE: if (sif.start_calc | sif.start_check) nxt_st = ENG_RUN;
         ENG_RUN:  if (last) nxt_st = ENG_IDLE;
         default:  nxt_st = ENG_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) st_ff <= ENG_IDLE;
      else st_ff <= nxt_st;
   end

   // Walk all config registers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         idx_ff <= '0;
         acc_ff <= 14'h0000;
         chk_ff <= 1'b0;
      end else if (!sif.busy && (sif.start_calc || sif.start_check)) begin
         idx_ff <= '0;
         acc_ff <= 14'h0000;
         chk_ff <= sif.start_check;
      end else if (sif.busy) begin
         idx_ff <= idx_ff + IW'(1);
         acc_ff <= sum;
      end
   end

   // Stored value, never readable by software
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) sto_ff <= 14'h0000;
      else if (sif.busy && !chk_ff && last) sto_ff <= sum;
   end

   // ****************************************************
   // Checks
   // ****************************************************
   chk_store_calc: assert property (@(posedge clk) disable iff (!resetn)
      sif.busy && !chk_ff && last |=> sto_ff == $past(sum))
      else $error("stored checksum not updated");
endmodule : cfcm_sum

// >>> hw/cfcm_top.sv
`timescale 1ns/100ps
`include "cfcm_defs.svh"
// Functional notes
// - Keep reference, recompute checksum on each load
// - Reset command reloads shadow registers
// - Calculate command stores hidden config checksum
// - Check command mismatch sets error, fault response if status was clear and no watchdog expiry
// - Config error halts scanning and balancing
// - No dedicated communication fault flag
// - NAK with address on bad command
// - Wait for response from device above
// - Timeout depends on stack position
// - Timeout sends failure with own address
// - Target relays failure, plus data on reads
// - Failure reaches host within bounded time
// - Force ports idle after each communication
// - Incomplete wake-up sequence answered with NAK
// - Watchdog expiry puts device to sleep
// - Scan counter counts executed scans, measures
// - Fault pin low while fault bits set
module cfcm_top import cfcm_pkg::*; #(
   parameter int unsigned N_CFG    = 16,
   parameter int unsigned MAX_DEV  = 14,
   parameter int unsigned SCW      = 4,
   parameter int unsigned FAIL_CYC =
      $rtoi(`CFCM_FAIL_MS * 1.0e6 / `CFCM_CLK_NS),
   parameter int unsigned SEC_CYC  =
      $rtoi(`CFCM_SEC_S * 1.0e9 / `CFCM_CLK_NS),
   localparam int unsigned IW = (N_CFG > 1) ? $clog2(N_CFG) : 1
) (
   // Clock and reset
   input  wire logic            clk,
   input  wire logic            resetn,
   // Stack position and link speed
   input  wire logic [3:0]      stack_pos,
   input  wire logic [3:0]      stack_top_addr,
   input  wire logic [1:0]      dc_rate,
   // Decoded command
   input  wire logic            cmd_valid,
   input  wire cfcm_op_t        cmd_op,
   input  wire logic            cmd_for_me,
   input  wire logic            cmd_bcast,
   input  wire logic            cmd_bcast_ok,
   input  wire logic            cmd_crc_ok,
   input  wire logic            cmd_bits_ok,
   output wire logic            cmd_ready,
   // Response from device above
   input  wire logic            rsp_valid,
   input  wire logic            rsp_fail,
   // Daisy chain clock pin
   input  wire logic            dc_clk_pin,
   // Nonvolatile load stream
   output wire logic            nvm_reload_req,
   input  wire logic            nvm_wr_valid,
   input  wire logic [2:0]      nvm_wr_page,
   input  wire logic [5:0]      nvm_wr_addr,
   input  wire logic [13:0]     nvm_wr_data,
   // Register read
   input  wire logic [2:0]      rd_page,
   input  wire logic [5:0]      rd_addr,
   output wire logic [13:0]     rd_data,
   // Config register fetch
   output wire logic [IW-1:0]   cfg_idx,
   input  wire logic [13:0]     cfg_word,
   // Fault status and alarm
   input  wire logic            fs_clr,
   input  wire logic [6:0]      wd_setting,
   output wire logic [13:0]     fault_status,
   output wire logic            fault_n,
   output wire logic            fault_rsp,
   // Responses sent down the chain
   output wire logic            nak_send,
   output wire logic            fail_send,
   output wire logic            relay_fail,
   output wire logic            relay_data,
   output wire logic [3:0]      rsp_addr,
   // Activity control
   output wire logic            scan_go,
   output wire logic [SCW-1:0]  scan_count,
   output wire logic            activity_halt,
   output wire logic            sleep,
   output wire logic            port_idle_force
);
   // ****************************************************
   // Constants and parameter checks
   // ****************************************************
   localparam int unsigned STEP     = FAIL_CYC / (MAX_DEV + 1);
   localparam int unsigned IDLE_CYC =
      $rtoi(`CFCM_IDLE_US * 1000.0 / `CFCM_CLK_NS);
   localparam int SUM_WIN = N_CFG + 1;

   if (MAX_DEV < 2 || MAX_DEV > 16 || N_CFG < 1 || SCW < 1 ||
       STEP < 1 || SEC_CYC < 1) begin : g_bad_param
      $error("cfcm_top parameter out of range");
   end

   // ****************************************************
   // Declarations
   // ****************************************************
   cfcm_sum_if #(.IW(IW)) sif ();       // Checksum engine link

   logic            load_ff;            // Reload request pulse
   logic [13:0]     ref_ff;             // Reference checksum
   logic [13:0]     cmp_ff;             // Computed checksum
   logic [13:0]     rd_ff;              // Read data
   logic [13:0]     fs_ff;              // Fault status bits
   logic            fault_n_ff;         // Alarm pin
   logic            frsp_ff;            // Fault response pulse
   logic            nak_ff;             // NAK pulse
   logic            fail_ff;            // Failure pulse
   logic            relay_ff;           // Relay pulse
   logic            rdat_ff;            // Relay carries data
   logic [3:0]      addr_ff;            // Address in response
   logic            wait_ff;            // Waiting on device above
   logic            tgt_ff;             // Waited command was ours
   logic            rd_cmd_ff;          // Waited command was read
   logic [31:0]     tcnt_ff;            // Response timer
   logic            scan_ff;            // Scan start pulse
   logic [SCW-1:0]  scnt_ff;            // Scan counter
   logic            sleep_ff;           // Sleep mode
   logic [31:0]     pre_ff;             // Second prescaler
   logic [13:0]     sec_ff;             // Watchdog seconds
   logic            sy1_ff;             // Pin sync stage one
   logic            sy2_ff;             // Pin sync stage two
   logic            sy3_ff;             // Edge history
   logic            lbusy_ff;           // Link active
   logic [15:0]     icnt_ff;            // Idle gap counter
   logic            idle_ff;            // Idle force pulse
   logic [13:0]     nxt_fs;             // Next fault status

   // ****************************************************
   // Command decode
   // ****************************************************
   wire logic cmd_take = cmd_valid & cmd_ready;
   // Bad CRC, illegal broadcast, short frame or half wake-up
   wire logic bad_cmd  = ~cmd_crc_ok | (cmd_bcast & ~cmd_bcast_ok) |
                         ~cmd_bits_ok;
   wire logic nak_now  = cmd_take & cmd_for_me & bad_cmd;
   wire logic good     = cmd_take & ~bad_cmd;
   wire logic is_scan  = (cmd_op == OP_SCAN) | (cmd_op == OP_MEAS);
   wire logic par_now  = fs_ff[`CFCM_FS_PAR] | sif.mismatch;
   wire logic scan_now = good & is_scan & ~par_now & ~sleep_ff;
   wire logic no_wait  = is_scan | (cmd_op == OP_RESET);
   wire logic at_top   = stack_pos == stack_top_addr;
   wire logic wait_now = good & ~no_wait & ~at_top;
   wire logic reset_go = good & (cmd_op == OP_RESET);

   // Engine idle before accepting anything new
   assign cmd_ready       = ~sif.busy;
   assign sif.start_calc  = good & (cmd_op == OP_CALC);
   assign sif.start_check = good & (cmd_op == OP_CHECK);
   assign sif.word        = cfg_word;
   assign cfg_idx         = sif.idx;

   cfcm_sum #(.N_CFG(N_CFG)) u_sum (
      .clk    (clk),
      .resetn (resetn),
      .sif    (sif)
   );

   // ****************************************************
   // Nonvolatile checksums
   // ****************************************************
   wire logic ref_hit = nvm_wr_page == `CFCM_PG_REF &&
                        nvm_wr_addr == `CFCM_AD_REF;

   // Reload after reset release and on Reset command
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) load_ff <= 1'b1;
      else load_ff <= reset_go;
   end

   // Reference captured, every other word summed
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ref_ff <= 14'h0000;
         cmp_ff <= 14'h0000;
      end else if (load_ff) begin
         cmp_ff <= 14'h0000;
      end else if (nvm_wr_valid && ref_hit) begin
         ref_ff <= nvm_wr_data;
      end else if (nvm_wr_valid) begin
         cmp_ff <= cmp_ff + nvm_wr_data;
      end
   end

   // Read port, unmapped reads zero
   wire logic rd_ref = rd_page == `CFCM_PG_REF && rd_addr == `CFCM_AD_REF;
   wire logic rd_cmp = rd_page == `CFCM_PG_CMP && rd_addr == `CFCM_AD_CMP;
   wire logic [13:0] rd_sel = rd_ref ? ref_ff : rd_cmp ? cmp_ff : 14'h0000;

   // Registered read data
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) rd_ff <= 14'h0000;
      else rd_ff <= rd_sel;
   end

   // ****************************************************
   // Fault status and alarm
   // ****************************************************
   wire logic wd_en  = |wd_setting;
   wire logic [13:0] wd_lim = wd_setting[6] ?
      (({8'h00, wd_setting[5:0]} + 14'h0001) * `CFCM_MIN_S) :
      {8'h00, wd_setting[5:0]};
   wire logic wd_exp = wd_en & (sec_ff >= wd_lim) & ~sleep_ff;

   // Set beats clear; no bit for link faults
   always_comb begin
      nxt_fs = fs_clr ? `CFCM_FS_RST : fs_ff;
      if (sif.mismatch) nxt_fs[`CFCM_FS_PAR] = 1'b1;
      if (wd_exp) nxt_fs[`CFCM_FS_WDG] = 1'b1;
   end

   // Status, alarm pin and first-fault response
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fs_ff      <= `CFCM_FS_RST;
         fault_n_ff <= 1'b1;
         frsp_ff    <= 1'b0;
      end else begin
         fs_ff      <= nxt_fs;
         fault_n_ff <= ~|nxt_fs;
         frsp_ff    <= ~|fs_ff & |nxt_fs & ~wd_exp;
      end
   end

   // ****************************************************
   // Watchdog
   // ****************************************************
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pre_ff <= 32'h0;
         sec_ff <= 14'h0000;
      end else if (cmd_take || !wd_en) begin
         pre_ff <= 32'h0;
         sec_ff <= 14'h0000;
      end else if (pre_ff == SEC_CYC - 1) begin
         pre_ff <= 32'h0;
         sec_ff <= sec_ff + 14'h0001;
      end else begin
         pre_ff <= pre_ff + 32'h1;
      end
   end

   // Sleep entered on expiry, left on good wake-up
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) sleep_ff <= 1'b0;
      else if (wd_exp) sleep_ff <= 1'b1;
      else if (good && cmd_op == OP_WAKE) sleep_ff <= 1'b0;
      else if (good && cmd_op == OP_SLEEP) sleep_ff <= 1'b1;
   end

   // ****************************************************
   // Scan counter
   // ****************************************************
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         scnt_ff <= '0;
         scan_ff <= 1'b0;
      end else begin
         scan_ff <= scan_now;
         if (scan_now) scnt_ff <= scnt_ff + SCW'(1);
      end
   end

   // ****************************************************
   // Response wait and timeout
   // ****************************************************
   // Deeper devices get more steps, doubled per rate halving
   wire logic [31:0] depth   = {28'h0, stack_top_addr - stack_pos} + 32'h1;
   wire logic [31:0] tmo_lim = (STEP * depth) << dc_rate;
   wire logic tmo_hit = wait_ff & ~rsp_valid & (tcnt_ff >= tmo_lim - 1);
   wire logic got_rsp = wait_ff & rsp_valid;

   // Wait state and timer
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wait_ff   <= 1'b0;
         tgt_ff    <= 1'b0;
         rd_cmd_ff <= 1'b0;
         tcnt_ff   <= 32'h0;
      end else if (wait_now) begin
         wait_ff   <= 1'b1;
         tgt_ff    <= cmd_for_me;
         rd_cmd_ff <= cmd_op == OP_READ;
         tcnt_ff   <= 32'h0;
      end else if (got_rsp || tmo_hit) begin
         wait_ff   <= 1'b0;
      end else if (wait_ff) begin
         tcnt_ff   <= tcnt_ff + 32'h1;
      end
   end

   // Outgoing NAK, failure and relay pulses
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         nak_ff   <= 1'b0;
         fail_ff  <= 1'b0;
         relay_ff <= 1'b0;
         rdat_ff  <= 1'b0;
         addr_ff  <= 4'h0;
      end else begin
         nak_ff   <= nak_now;
         fail_ff  <= tmo_hit;
         relay_ff <= got_rsp & rsp_fail & tgt_ff;
         if (got_rsp && rsp_fail && tgt_ff) rdat_ff <= rd_cmd_ff;
         if (nak_now || tmo_hit) addr_ff <= stack_pos;
      end
   end

   // ****************************************************
   // Link activity and idle forcing
   // ****************************************************
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sy1_ff <= 1'b0;
         sy2_ff <= 1'b0;
         sy3_ff <= 1'b0;
      end else begin
         sy1_ff <= dc_clk_pin;
         sy2_ff <= sy1_ff;
         sy3_ff <= sy2_ff;
      end
   end

   wire logic lk_edge = sy2_ff ^ sy3_ff;

   // Quiet gap ends a frame and re-idles the ports
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         lbusy_ff <= 1'b0;
         icnt_ff  <= 16'h0000;
         idle_ff  <= 1'b0;
      end else begin
         idle_ff <= 1'b0;
         if (lk_edge) begin
            lbusy_ff <= 1'b1;
            icnt_ff  <= 16'h0000;
         end else if (lbusy_ff && icnt_ff == 16'(IDLE_CYC - 1)) begin
            lbusy_ff <= 1'b0;
            idle_ff  <= 1'b1;
         end else if (lbusy_ff) begin
            icnt_ff  <= icnt_ff + 16'h0001;
         end
      end
   end

   // ****************************************************
   // Outputs
   // ****************************************************
   assign nvm_reload_req  = load_ff;
   assign rd_data         = rd_ff;
   assign fault_status    = fs_ff;
   assign fault_n         = fault_n_ff;
   assign fault_rsp       = frsp_ff;
   assign nak_send        = nak_ff;
   assign fail_send       = fail_ff;
   assign relay_fail      = relay_ff;
   assign relay_data      = rdat_ff;
   assign rsp_addr        = addr_ff;
   assign scan_go         = scan_ff;
   assign scan_count      = scnt_ff;
   assign activity_halt   = fs_ff[`CFCM_FS_PAR] | sleep_ff;
   assign sleep           = sleep_ff;
   assign port_idle_force = idle_ff;

   // ****************************************************
   // Checks
   // ****************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence s_check_cmd;
      sif.start_check && !sif.busy;
   endsequence
   sequence s_check_done;
      sif.busy ##[1:SUM_WIN] !sif.busy;
   endsequence

   chk_check_bound: assert property (s_check_cmd |=> s_check_done)
      else $error("checksum check did not finish");
   chk_busy_block: assert property (sif.busy |-> !cmd_ready)
      else $error("command accepted during checksum");
   chk_par_halt: assert property (fs_ff[`CFCM_FS_PAR] |-> activity_halt)
      else $error("activity not halted on config error");
   chk_alarm_pin: assert property (fault_n == (fs_ff == 14'h0000))
      else $error("alarm pin disagrees with status");
   chk_nak_addr: assert property (cmd_take && cmd_for_me && !cmd_crc_ok
      |=> nak_send && rsp_addr == $past(stack_pos))
      else $error("missing NAK on bad CRC");
   chk_wake_nak: assert property (cmd_take && cmd_for_me &&
      cmd_op == OP_WAKE && !cmd_bits_ok |=> nak_send)
      else $error("short wake-up not refused");
   chk_scan_inc: assert property (scan_now
      |=> scan_count == $past(scan_count) + SCW'(1))
      else $error("scan counter did not step");
   chk_fail_bound: assert property (wait_ff
      |-> tmo_lim <= (32'(FAIL_CYC) << dc_rate))
      else $error("timeout beyond failure bound");
   chk_fail_time: assert property (fail_send
      |-> $past(wait_ff) && !$past(rsp_valid))
      else $error("failure sent without timeout");
   chk_reload_go: assert property (reset_go
      |=> nvm_reload_req ##1 cmp_ff == 14'h0000)
      else $error("reset did not reload");
   chk_idle_end: assert property (port_idle_force
      |-> !lbusy_ff && $past(lbusy_ff))
      else $error("idle forced outside frame end");
endmodule : cfcm_top

// >>> pkg/cfcm_defs.svh
`ifndef CFCM_DEFS_SVH
`define CFCM_DEFS_SVH
// ****************************************************
// Register map
// ****************************************************
`define CFCM_PG_REF   3'h4
`define CFCM_AD_REF   6'h3f
`define CFCM_PG_CMP   3'h5
`define CFCM_AD_CMP   6'h00
// ****************************************************
// Fault status layout
// ****************************************************
`define CFCM_FS_PAR   4
`define CFCM_FS_WDG   5
`define CFCM_FS_RST   14'h0000
// ****************************************************
// Timing
// ****************************************************
`define CFCM_CLK_NS   10.0
`define CFCM_FAIL_MS  5.8
`define CFCM_IDLE_US  4.0
`define CFCM_SEC_S    1.0
`define CFCM_MIN_S    14'h0078
`endif

// >>> pkg/cfcm_pkg.sv
package cfcm_pkg;
   // Decoded daisy chain commands
   typedef enum logic [3:0] {
      OP_SCAN, OP_MEAS, OP_RESET, OP_READ, OP_WRITE, OP_BAL,
      OP_ACK, OP_SLEEP, OP_WAKE, OP_CALC, OP_CHECK, OP_OTHER
   } cfcm_op_t;
   // Checksum engine states
   typedef enum logic {ENG_IDLE, ENG_RUN} cfcm_eng_t;
endpackage : cfcm_pkg

// >>> pkg/cfcm_sum_if.sv
`timescale 1ns/100ps
interface cfcm_sum_if #(parameter int unsigned IW = 4);
   logic          start_calc;  // Store a fresh checksum
   logic          start_check; // Recompute and compare
   logic          busy;        // Engine walking the registers
   logic          mismatch;    // Compare failed, last step
   logic [IW-1:0] idx;         // Config register index
   logic [13:0]   word;        // Config register contents
   modport ctl (output start_calc, output start_check, output word,
                input busy, input mismatch, input idx);
   modport eng (input start_calc, input start_check, input word,
                output busy, output mismatch, output idx);
endinterface : cfcm_sum_if

// >>> tb/cfcm_far_model.sv
`timescale 1ns/100ps
module cfcm_far_model (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // Nonvolatile load stream
   input  wire logic        nvm_reload_req,
   output logic             nvm_wr_valid = 1'b0,
   output logic [2:0]       nvm_wr_page = 3'h0,
   output logic [5:0]       nvm_wr_addr = 6'h00,
   output logic [13:0]      nvm_wr_data = 14'h0000,
   // Config registers
   input  wire logic [1:0]  cfg_idx,
   output wire logic [13:0] cfg_word,
   // Device above
   input  wire logic        rsp_req,
   input  wire logic        rsp_bad,
   output logic             rsp_valid = 1'b0,
   output logic             rsp_fail = 1'b0,
   // Link clock, still outside frames
   input  wire logic        frame,
   output logic             dc_clk_pin = 1'b0
);
   logic [13:0] cfg [4] = '{14'h0011, 14'h0022, 14'h0033, 14'h0044};
   int          k = 0;   // Stream step
   int          d = 0;   // Answer delay
   assign cfg_word = cfg[cfg_idx];
   // Three words per reload, reference in the middle
   always @(posedge clk) begin
      nvm_wr_valid <= (k > 0 && k < 4);
      nvm_wr_page  <= (k == 2) ? 3'h4 : 3'h1;
      nvm_wr_addr  <= (k == 2) ? 6'h3f : 6'(k);
      case (k)
         1: nvm_wr_data <= 14'h1234;
         2: nvm_wr_data <= 14'h2345;
         3: nvm_wr_data <= 14'h3fff;
         default: nvm_wr_data <= ~nvm_wr_data;
      endcase
      k <= !resetn ? 0 : nvm_reload_req ? 1 : ((k > 0 && k < 4) ? k + 1 : 0);
      // Upstream answer, stale flag inverted when idle
      d <= rsp_req ? 20 : ((d > 0) ? d - 1 : 0);
      rsp_valid <= (d == 1);
      rsp_fail  <= (d == 1) ? rsp_bad : ~rsp_fail;
   end
   // 80 ns link clock, phase unrelated to clk
   initial begin
      #13;
      forever #40 dc_clk_pin <= frame ? ~dc_clk_pin : 1'b0;
   end
endmodule : cfcm_far_model

// >>> tb/tb_comm_fault_checksum_monitor.sv
`timescale 1ns/100ps
module tb_comm_fault_checksum_monitor import cfcm_pkg::*; ;
   logic clk = 0, resetn = 0, cmd_valid = 0, cmd_for_me = 1, cmd_bcast = 0;
   logic cmd_bcast_ok = 1, cmd_crc_ok = 1, cmd_bits_ok = 1, fs_clr = 0;
   logic rsp_req = 0, rsp_bad = 0, frame = 0;
   logic [3:0] stack_pos = 4'h2, stack_top_addr = 4'h5;
   logic [1:0] dc_rate = 2'h0;
   logic [2:0] rd_page = 3'h0;
   logic [5:0] rd_addr = 6'h00;
   logic [6:0] wd_setting = 7'h00;
   cfcm_op_t   cmd_op = OP_OTHER;
   wire logic rsp_valid, rsp_fail, dc_clk_pin, nvm_reload_req, nvm_wr_valid;
   wire logic cmd_ready, fault_n, fault_rsp, nak_send, fail_send, relay_fail;
   wire logic relay_data, scan_go, activity_halt, sleep, port_idle_force;
   wire logic [1:0] cfg_idx;
   wire logic [2:0] nvm_wr_page;
   wire logic [3:0] rsp_addr, scan_count;
   wire logic [5:0] nvm_wr_addr;
   wire logic [13:0] nvm_wr_data, rd_data, cfg_word, fault_status;
   int fail_count = 0, num_checks = 0, n;
   cfcm_top #(.N_CFG(4), .SCW(4), .FAIL_CYC(3200), .SEC_CYC(50)) DUT (.*);
   cfcm_far_model far (.*);
   initial forever #5 clk = ~clk;
   task automatic check(input logic [13:0] got, input logic [13:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   // One command, driven for one cycle once the block is ready
   task automatic send(input cfcm_op_t op, input logic r);
      // Edge gap, so a strobe never drops and rises at one instant
      @(negedge clk);
      for (int i = 0; i < 40 && cmd_ready !== 1'b1; i++) @(negedge clk);
      cmd_op = op; cmd_valid = 1; rsp_req = r;
      @(negedge clk);
      cmd_valid = 0; rsp_req = 0;
   endtask : send
   function automatic logic pick(input int k);
      case (k)
         0: return fault_rsp;
         1: return nak_send;
         2: return fail_send;
         3: return relay_fail;
         4: return scan_go;
         5: return port_idle_force;
         default: return sleep;
      endcase
   endfunction : pick
   // Cycles until a pulse, lim if it never comes
   task automatic wait_pulse(input int k, input int lim);
      for (n = 0; n < lim && pick(k) !== 1'b1; n++) @(negedge clk);
   endtask : wait_pulse
   task automatic rd(input logic [2:0] p, input logic [5:0] a,
                     input logic [13:0] e);
      rd_page = p; rd_addr = a;
      @(negedge clk);
      check(rd_data, e);
   endtask : rd
   task automatic t_nvm;
      repeat (8) @(negedge clk);
      rd(3'h5, 6'h00, 14'h1233);
      rd(3'h4, 6'h3f, 14'h2345);
      send(OP_RESET, 0);
      repeat (8) @(negedge clk);
      rd(3'h5, 6'h00, 14'h1233);
      $display("nvm test done");
   endtask : t_nvm
   task automatic t_scan;
      logic [3:0] c;
      c = scan_count;
      for (int i = 0; i < 2; i++) begin
         send(i ? OP_MEAS : OP_SCAN, 0);
         wait_pulse(4, 4);
         check(n < 4, 1);
      end
      @(negedge clk);
      check(scan_count, c + 4'h2);
      $display("scan test done");
   endtask : t_scan
   task automatic t_par;
      send(OP_CALC, 0);
      send(OP_CHECK, 0);
      @(negedge clk);
      check(cmd_ready, 0);
      wait_pulse(0, 10);
      check(n, 10);
      check(fault_status[4], 0);
      far.cfg[1] = 14'h0123;
      send(OP_CHECK, 0);
      wait_pulse(0, 10);
      check(n < 10, 1);
      check(fault_status[4], 1);
      check(fault_n, 0);
      check(activity_halt, 1);
      send(OP_SCAN, 0);
      wait_pulse(4, 4);
      check(n, 4);
      far.cfg[1] = 14'h0022;
      fs_clr = 1;
      @(negedge clk);
      fs_clr = 0;
      @(negedge clk);
      check(fault_status, 0);
      check(fault_n, 1);
      $display("checksum test done");
   endtask : t_par
   task automatic t_nak;
      for (int i = 0; i < 3; i++) begin
         cmd_crc_ok = (i != 0); cmd_bcast = (i == 1);
         cmd_bcast_ok = (i != 1); cmd_bits_ok = (i != 2);
         send(OP_WRITE, 0);
         wait_pulse(1, 4);
         check(n < 4, 1);
         check(rsp_addr, stack_pos);
      end
      cmd_crc_ok = 1; cmd_bcast = 0; cmd_bcast_ok = 1; cmd_bits_ok = 1;
      send(OP_ACK, 0);
      $display("nak test done");
   endtask : t_nak
   task automatic t_tmo;
      for (int p = 2; p < 5; p += 2) begin
         stack_pos = 4'(p);
         send(OP_WRITE, 0);
         wait_pulse(2, 900);
         check(n + 2 >= 213 * (6 - p) && n <= 213 * (6 - p) + 1, 1);
         check(rsp_addr, stack_pos);
      end
      stack_pos = 4'h2; rsp_bad = 1;
      for (int i = 0; i < 2; i++) begin
         send(i ? OP_WRITE : OP_READ, 1);
         wait_pulse(3, 40);
         check(n < 40, 1);
         check(relay_data, !i);
      end
      wait_pulse(2, 900);
      check(n, 900);
      $display("timeout test done");
   endtask : t_tmo
   task automatic t_link;
      frame = 1;
      repeat (160) @(negedge clk);
      frame = 0;
      wait_pulse(5, 500);
      check(n >= 390 && n <= 415, 1);
      $display("link test done");
   endtask : t_link
   // Sleep by command, refused and good wake-up, then watchdog expiry
   task automatic t_sleep;
      send(OP_SLEEP, 0);
      check(sleep, 1);
      cmd_bits_ok = 0;
      send(OP_WAKE, 0);
      wait_pulse(1, 4);
      check(n < 4 && sleep, 1);
      cmd_bits_ok = 1;
      send(OP_WAKE, 0);
      check(sleep, 0);
      wd_setting = 7'h01;
      wait_pulse(6, 60);
      check(n >= 50 && n <= 52, 1);
      check(fault_status[5], 1);
      wd_setting = 7'h00;
      send(OP_SCAN, 0);
      wait_pulse(4, 4);
      check(n, 4);
      $display("sleep test done");
   endtask : t_sleep
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : complete_run
   initial begin
      repeat (4) @(negedge clk);
      resetn = 1;
      t_nvm(); t_scan(); t_par(); t_nak(); t_tmo(); t_link(); t_sleep();
      complete_run();
   end
   initial begin
      #300us;
      fail_count++;
      complete_run();
   end
endmodule : tb_comm_fault_checksum_monitor
